/* File: rtccal_pkg.sv */
// rtccal_pkg: offsets, field layout, reset values and helpers of the calendar
package rtccal_pkg;

  // ****************************************************************
  // register map (16-bit registers, byte addresses)
  // ****************************************************************
  localparam int          ADDR_W       = 5;
  localparam int          DATA_W       = 16;
  localparam int          NUM_ZONES    = 3;
  localparam logic [4:0]  OFS_HM_BASE  = 5'h00;
  localparam logic [4:0]  OFS_MD_BASE  = 5'h06;
  localparam logic [4:0]  OFS_YW_BASE  = 5'h0C;
  localparam logic [4:0]  ZONE_STRIDE  = 5'h02;
  localparam logic [4:0]  OFS_FLAGS    = 5'h12;
  localparam logic [4:0]  OFS_ENABLES  = 5'h14;
  localparam logic [4:0]  OFS_CONTROL  = 5'h16;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int HM_AP_BIT     = 14;
  localparam int HM_HOUR_MSB   = 13;
  localparam int HM_HOUR_LSB   = 8;
  localparam int HM_MIN_MSB    = 6;
  localparam int HM_MIN_LSB    = 0;
  localparam int MD_MON_MSB    = 12;
  localparam int MD_MON_LSB    = 8;
  localparam int MD_DAY_MSB    = 5;
  localparam int MD_DAY_LSB    = 0;
  localparam int YW_WK_MSB     = 10;
  localparam int YW_WK_LSB     = 8;
  localparam int YW_YEAR_MSB   = 7;
  localparam int YW_YEAR_LSB   = 0;
  localparam int CTL_FMT24_BIT = 0;
  localparam int CTL_BUSY_BIT  = 1;

  // cause flag / enable bit positions
  localparam int FLAG_REGULATION = 15;
  localparam int FLAG_SW_ONE     = 14;
  localparam int FLAG_SW_TEN     = 13;
  localparam int FLAG_SW_HUNDRED = 12;
  localparam int FLAG_ALARM      = 8;
  localparam int FLAG_DAY        = 7;
  localparam int FLAG_HOUR       = 6;
  localparam int FLAG_MINUTE     = 5;
  localparam int FLAG_SECOND     = 4;
  localparam int FLAG_HALF       = 3;
  localparam int FLAG_QUARTER    = 2;
  localparam int FLAG_EIGHTH     = 1;
  localparam int FLAG_THIRTY_SEC = 0;
  localparam logic [15:0] FLAG_MASK      = 16'hF1FF;
  localparam logic [15:0] EXT_CAUSE_MASK = 16'hF11F;

  // ****************************************************************
  // reset values and counter limits (BCD)
  // ****************************************************************
  localparam logic [7:0]  RST_HOUR      = 8'h12;
  localparam logic [7:0]  RST_MINUTE    = 8'h00;
  localparam logic [7:0]  RST_MONTH     = 8'h01;
  localparam logic [7:0]  RST_DAY       = 8'h01;
  localparam logic [7:0]  RST_YEAR      = 8'h00;
  localparam logic [2:0]  RST_WEEKDAY   = 3'h0;
  localparam logic        RST_AFTERNOON = 1'b0;
  localparam logic        RST_FMT24     = 1'b0;
  localparam logic [15:0] RST_FLAGS     = 16'h0000;
  localparam logic [15:0] RST_ENABLES   = 16'h0000;
  localparam logic [7:0]  MINUTE_LAST   = 8'h59;
  localparam logic [7:0]  HOUR12_LAST   = 8'h12;
  localparam logic [7:0]  HOUR12_PRE    = 8'h11;
  localparam logic [7:0]  HOUR24_LAST   = 8'h23;
  localparam logic [7:0]  MONTH_LAST    = 8'h12;
  localparam logic [7:0]  YEAR_LAST     = 8'h99;
  localparam logic [7:0]  BCD_ONE       = 8'h01;
  localparam logic [7:0]  BCD_ZERO      = 8'h00;
  localparam logic [2:0]  WEEKDAY_LAST  = 3'h6;
  localparam logic [2:0]  WEEKDAY_FIRST = 3'h0;

  // two-digit BCD increment without wrap
  function automatic logic [7:0] rtccal_bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v + 8'h01;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end
    return r;
  endfunction

endpackage

/* File: rtccal_month_days.sv */
// rtccal_month_days: last day of a month in BCD, leap years included
module rtccal_month_days
  import rtccal_pkg::*;
(
  // calendar inputs, BCD
  input  wire logic [7:0] month,
  input  wire logic [7:0] year,
  // last valid day, BCD
  output logic      [7:0] lastDay
);

  // ****************************************************************
  // leap year test on BCD digits
  // ****************************************************************
  // even tens: units 0,4,8 divide by four; odd tens: units 2,6 do
  wire evenTens = ~year[4];
  wire unitsEvenCase = (year[3:0] == 4'h0) || (year[3:0] == 4'h4) ||
                       (year[3:0] == 4'h8);
  wire unitsOddCase  = (year[3:0] == 4'h2) || (year[3:0] == 4'h6);
  // year 00 counts as leap, the two-digit range cannot tell centuries
  wire leapYear = evenTens ? unitsEvenCase : unitsOddCase;

  // ****************************************************************
  // month length selection
  // ****************************************************************
  wire isFebruary = (month == 8'h02);
  wire isShort    = (month == 8'h04) || (month == 8'h06) ||
                    (month == 8'h09) || (month == 8'h11);

  // length per month class
  assign lastDay = isFebruary ? (leapYear ? 8'h29 : 8'h28) :
                   isShort    ? 8'h30 : 8'h31;

endmodule

/* File: rtccal_regs.sv */
// rtccal_regs: three-zone BCD calendar counters with cause flags and enables
//
// Summary of operation
// - in 12-hour format software sets and reads afternoon flag, 1 afternoon
// - in 24-hour format afternoon flag stays 0, writes of 1 ignored
// - flag left at 1 by switch to 24-hour clears at next hour step
// - hour is BCD tens/units, 1..12 or 0..23 by format
// - minute is BCD tens/units, 0..59, readable and writable
// - month is one-bit tens and four-bit units BCD, 1..12
// - day counts 1..31, shorter for February, April, June, Sept, Nov
// - weekday is a three-bit modulo-seven counter, 0x0..0x6 only
// - weekday codes: Sunday 0x0 through Saturday 0x6
// - year is two BCD digits covering 0..99
// - cause flags read 1 once set; write 1 clears, write 0 keeps
// - flag bits 15..12 regulation and stopwatch; bits 11..9 read 0
// - flag bits 8..0 alarm, day, hour, minute, second and fractions
// - enable register mirrors flag positions, readable and writable
// - enable 1 lets its cause request an interrupt, 0 blocks it
module rtccal_regs
  import rtccal_pkg::*;
#(
  parameter int ZONES = NUM_ZONES
)
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [DATA_W-1:0] regRdData,
  // timekeeping inputs from the second counter and its neighbours
  input  wire logic              minuteCarry,
  input  wire logic              counterBusy,
  input  wire logic [15:0]       causeEvent,
  // interrupt request and format state
  output logic                   irqRequest,
  output logic                   hourFormat24
);

  // ****************************************************************
  // address decoding
  // ****************************************************************
  // zone copies sit one stride apart above each base
  function automatic logic zoneHit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] base,
                                   input int                zone);
    logic [ADDR_W-1:0] target;
    target = base + ADDR_W'(zone) * ZONE_STRIDE;
    return addr == target;
  endfunction

  wire writeFlags   = regWrite && (regAddr == OFS_FLAGS);
  wire writeEnables = regWrite && (regAddr == OFS_ENABLES);
  wire writeControl = regWrite && (regAddr == OFS_CONTROL);

  // ****************************************************************
  // per-zone calendar state
  // ****************************************************************
  logic [7:0] hourVal  [ZONES];
  logic [7:0] minVal   [ZONES];
  logic [7:0] monVal   [ZONES];
  logic [7:0] dayVal   [ZONES];
  logic [7:0] yearVal  [ZONES];
  logic [2:0] wkVal    [ZONES];
  logic       afternoon[ZONES];
  logic       hourStep [ZONES];
  logic       dayStep  [ZONES];
  logic [DATA_W-1:0] hmWord[ZONES];
  logic [DATA_W-1:0] mdWord[ZONES];
  logic [DATA_W-1:0] ywWord[ZONES];
  logic [ZONES-1:0]  hmSel;
  logic [ZONES-1:0]  mdSel;
  logic [ZONES-1:0]  ywSel;

  logic        fmt24;
  logic [15:0] flags;
  logic [15:0] enables;

  genvar z;
  generate
    for (z = 0; z < ZONES; z++) begin : gZone
      logic [7:0] lastDay;
      logic [7:0] next_hour;
      logic       next_ap;
      logic       minWrap;
      logic       dayWrap;
      logic       monWrap;
      logic       hmWr;
      logic       mdWr;
      logic       ywWr;

      rtccal_month_days uDays (
        .month   (monVal[z]),
        .year    (yearVal[z]),
        .lastDay (lastDay)
      );

      // selects for this zone's three registers
      assign hmSel[z] = zoneHit(regAddr, OFS_HM_BASE, z);
      assign mdSel[z] = zoneHit(regAddr, OFS_MD_BASE, z);
      assign ywSel[z] = zoneHit(regAddr, OFS_YW_BASE, z);
      assign hmWr     = regWrite && hmSel[z];
      assign mdWr     = regWrite && mdSel[z];
      assign ywWr     = regWrite && ywSel[z];

      // carry chain from the minute tick upward
      assign minWrap     = (minVal[z] == MINUTE_LAST);
      assign hourStep[z] = minuteCarry && minWrap;
      // the day ends at 23 in 24-hour format, at 11 pm in 12-hour format
      assign dayStep[z]  = hourStep[z] &&
                           (fmt24 ? (hourVal[z] == HOUR24_LAST) :
                            ((hourVal[z] == HOUR12_PRE) && afternoon[z]));
      assign dayWrap     = (dayVal[z] == lastDay);
      assign monWrap     = (monVal[z] == MONTH_LAST);

      // hour ranges 1..12 or 0..23, am/pm toggles on 11 -> 12
      always_comb begin
        next_hour = rtccal_bcd_inc(hourVal[z]);
        next_ap   = afternoon[z];
        if (fmt24) begin
          next_ap = 1'b0;
          if (hourVal[z] == HOUR24_LAST) begin
            next_hour = BCD_ZERO;
          end
        end else if (hourVal[z] == HOUR12_LAST) begin
          next_hour = BCD_ONE;
        end else if (hourVal[z] == HOUR12_PRE) begin
          next_ap = ~afternoon[z];
        end
      end

      // hour/minute register: write replaces, else count
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          hourVal[z]   <= RST_HOUR;
          minVal[z]    <= RST_MINUTE;
          afternoon[z] <= RST_AFTERNOON;
        end else if (hmWr) begin
          hourVal[z] <= {2'b00, regWrData[HM_HOUR_MSB:HM_HOUR_LSB]};
          minVal[z]  <= {1'b0, regWrData[HM_MIN_MSB:HM_MIN_LSB]};
          // 24-hour: a 0 still clears, a 1 leaves the bit alone
          if (!fmt24) begin
            afternoon[z] <= regWrData[HM_AP_BIT];
          end else if (!regWrData[HM_AP_BIT]) begin
            afternoon[z] <= 1'b0;
          end
        end else if (minuteCarry) begin
          minVal[z] <= minWrap ? BCD_ZERO : rtccal_bcd_inc(minVal[z]);
          if (hourStep[z]) begin
            hourVal[z]   <= next_hour;
            afternoon[z] <= next_ap;
          end
        end
      end

      // month/day register
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          monVal[z] <= RST_MONTH;
          dayVal[z] <= RST_DAY;
        end else if (mdWr) begin
          monVal[z] <= {3'b000, regWrData[MD_MON_MSB:MD_MON_LSB]};
          dayVal[z] <= {2'b00, regWrData[MD_DAY_MSB:MD_DAY_LSB]};
        end else if (dayStep[z]) begin
          dayVal[z] <= dayWrap ? BCD_ONE : rtccal_bcd_inc(dayVal[z]);
          if (dayWrap) begin
            monVal[z] <= monWrap ? BCD_ONE : rtccal_bcd_inc(monVal[z]);
          end
        end
      end

      // year/weekday register
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          yearVal[z] <= RST_YEAR;
          wkVal[z]   <= RST_WEEKDAY;
        end else if (ywWr) begin
          yearVal[z] <= regWrData[YW_YEAR_MSB:YW_YEAR_LSB];
          // code 7 is not a weekday; it is taken as Sunday
          wkVal[z] <= (regWrData[YW_WK_MSB:YW_WK_LSB] > WEEKDAY_LAST) ?
                      WEEKDAY_FIRST : regWrData[YW_WK_MSB:YW_WK_LSB];
        end else if (dayStep[z]) begin
          wkVal[z] <= (wkVal[z] == WEEKDAY_LAST) ? WEEKDAY_FIRST :
                      wkVal[z] + 3'h1;
          if (dayWrap && monWrap) begin
            yearVal[z] <= (yearVal[z] == YEAR_LAST) ? BCD_ZERO :
                          rtccal_bcd_inc(yearVal[z]);
          end
        end
      end

      // read images, reserved bits tied to zero
      assign hmWord[z] = {1'b0, afternoon[z], hourVal[z][5:0],
                          1'b0, minVal[z][6:0]};
      assign mdWord[z] = {3'b000, monVal[z][4:0], 2'b00, dayVal[z][5:0]};
      assign ywWord[z] = {5'b00000, wkVal[z], yearVal[z]};
    end
  endgenerate

  // ****************************************************************
  // control register: hour format and busy status
  // ****************************************************************
  // writes during busy are not blocked here; software owes the wait
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fmt24 <= RST_FMT24;
    end else if (writeControl) begin
      fmt24 <= regWrData[CTL_FMT24_BIT];
    end
  end

  // ****************************************************************
  // cause flags and enables
  // ****************************************************************
  // day and hour causes follow the main zone's own carries, the minute cause follows the shared minuteCarry input
  logic [15:0] setVector;
  logic [15:0] next_flags;
  logic [15:0] next_enables;

  always_comb begin
    setVector              = causeEvent & EXT_CAUSE_MASK;
    setVector[FLAG_DAY]    = dayStep[0];
    setVector[FLAG_HOUR]   = hourStep[0];
    setVector[FLAG_MINUTE] = minuteCarry;
  end

  // a cause arriving with its clear keeps the flag set
  assign next_flags = ((flags & ~({16{writeFlags}} & regWrData)) |
                       setVector) & FLAG_MASK;
  assign next_enables = writeEnables ? (regWrData & FLAG_MASK) :
                        enables;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags   <= RST_FLAGS;
      enables <= RST_ENABLES;
    end else begin
      flags   <= next_flags;
      enables <= next_enables;
    end
  end

  // request built from next state so it moves with the flag register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irqRequest <= 1'b0;
    end else begin
      irqRequest <= |(next_flags & next_enables);
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [DATA_W-1:0] readMux;

  always_comb begin
    readMux = '0;
    for (int i = 0; i < ZONES; i++) begin
      if (hmSel[i]) readMux = hmWord[i];
      if (mdSel[i]) readMux = mdWord[i];
      if (ywSel[i]) readMux = ywWord[i];
    end
    if (regAddr == OFS_FLAGS) readMux = flags;
    if (regAddr == OFS_ENABLES) readMux = enables;
    if (regAddr == OFS_CONTROL) begin
      readMux = '0;
      readMux[CTL_FMT24_BIT] = fmt24;
      readMux[CTL_BUSY_BIT]  = counterBusy;
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regRdData    <= '0;
      hourFormat24 <= RST_FMT24;
    end else begin
      regRdData    <= regRead ? readMux : '0;
      hourFormat24 <= writeControl ? regWrData[CTL_FMT24_BIT] : fmt24;
    end
  end

endmodule

/* File: rtccal_regs_checker.sv */
// rtccal_regs_checker: port-level assertions for the calendar registers
module rtccal_regs_checker
  import rtccal_pkg::*;
#(
  parameter int ZONES = NUM_ZONES
)
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              reset,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic              regWrite,
  input wire logic              regRead,
  input wire logic [DATA_W-1:0] regRdData,
  // timekeeping inputs
  input wire logic              minuteCarry,
  input wire logic              counterBusy,
  input wire logic [15:0]       causeEvent,
  // request and format
  input wire logic              irqRequest,
  input wire logic              hourFormat24
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ****************************************************************
  // decoded accesses
  // ****************************************************************
  // any cause that may set a flag this cycle, counting carries included
  wire enWr     = regWrite && regAddr == OFS_ENABLES;
  wire flWr     = regWrite && regAddr == OFS_FLAGS;
  wire ctlWr    = regWrite && regAddr == OFS_CONTROL;
  wire anyCause = minuteCarry || |(causeEvent & EXT_CAUSE_MASK);

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_enable_blocks: assert property (enWr && regWrData == 16'h0000 |=> !irqRequest)
    else $error("request stays up with all enables cleared");
  a_clear_drops: assert property (flWr && regWrData == 16'hFFFF && !anyCause
    |=> !irqRequest)
    else $error("request stays up after clearing every flag");
  a_irq_cause: assert property ($rose(irqRequest) |-> $past(anyCause || enWr))
    else $error("request rose without cause or enable write");
  a_irq_drop: assert property ($fell(irqRequest) |-> $past(enWr || flWr))
    else $error("request fell without a flag or enable write");
  a_format_load: assert property (ctlWr |=> hourFormat24 == $past(regWrData[0]))
    else $error("format output does not follow control write");
  a_format_hold: assert property (!ctlWr |=> $stable(hourFormat24))
    else $error("format output moved without a control write");
  a_flag_seen: assert property (causeEvent[FLAG_ALARM] ##1 !regWrite
    ##1 (regRead && regAddr == OFS_FLAGS) |=> regRdData[FLAG_ALARM])
    else $error("alarm flag not read back after its cause");
  a_resv_flags: assert property (regRead && (regAddr == OFS_FLAGS
    || regAddr == OFS_ENABLES) |=> regRdData[11:9] == 3'h0)
    else $error("reserved flag bits read nonzero");
  a_resv_hour: assert property (regRead && regAddr < OFS_MD_BASE
    |=> regRdData[15] == 1'b0 && regRdData[7] == 1'b0)
    else $error("reserved hour register bits read nonzero");
  a_weekday_range: assert property (regRead && regAddr >= OFS_YW_BASE
    && regAddr < OFS_FLAGS |=> regRdData[10:8] != 3'h7)
    else $error("weekday read outside its range");

  // main scenarios reached
  c_irq_up: cover property ($rose(irqRequest));
  c_fmt24: cover property (ctlWr && regWrData[0]);
  c_carry24: cover property (minuteCarry && hourFormat24);
endmodule

/* File: testbench.sv */
// testbench: self-checking bench for the three-zone calendar registers
module testbench
  import rtccal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // signals, model and counters
  // ****************************************************************
  logic              ref_clk;
  logic              reset;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData;
  logic              regWrite;
  logic              regRead;
  logic [DATA_W-1:0] regRdData;
  logic              minuteCarry;
  logic              counterBusy;
  logic [15:0]       causeEvent;
  logic              irqRequest;
  logic              hourFormat24;
  logic [15:0]       got;
  logic [15:0]       c;
  int                nErrors = 0;
  int                checksDone = 0;
  int                seed = 76;
  int unsigned       u;
  int                model[int];
  // calendar steps: month/day, year/weekday, then expected after 23:59
  logic [15:0]       cal[4][4] = '{
    '{16'h0228, 16'h0623, 16'h0301, 16'h0023},
    '{16'h0228, 16'h0124, 16'h0229, 16'h0224},
    '{16'h0430, 16'h0399, 16'h0501, 16'h0499},
    '{16'h1231, 16'h0599, 16'h0101, 16'h0600}};

  rtccal_regs #(.ZONES(NUM_ZONES)) DUT (
    .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .minuteCarry(minuteCarry),
    .counterBusy(counterBusy), .causeEvent(causeEvent),
    .irqRequest(irqRequest), .hourFormat24(hourFormat24));

  // 25 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chkReg(input logic [15:0] g, input logic [15:0] e);
    checksDone++;
    if (g !== e) begin
      nErrors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkBit(input logic g, input logic e);
    checksDone++;
    if (g !== e) begin
      nErrors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  // writable bits; unmapped slots keep nothing
  function automatic logic [15:0] wmask(input int a);
    if (a < OFS_MD_BASE) return 16'h7F7F;
    if (a < OFS_YW_BASE) return 16'h1F3F;
    if (a < OFS_FLAGS) return 16'h07FF;
    if (a == OFS_ENABLES) return 16'hF1FF;
    if (a == OFS_CONTROL) return 16'h0001;
    return 16'h0000;
  endfunction

  // one write cycle, then an idle cycle so strobes never double-drive
  task automatic wr(input int a, input logic [15:0] d);
    logic [15:0] v;
    v = d & wmask(a);
    if (a < OFS_MD_BASE && model[OFS_CONTROL][0]) v[14] = v[14] & model[a][14];
    if (a == OFS_FLAGS) v = model[a][15:0] & ~d;
    model[a] = v;
    regAddr <= a[4:0];
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input int a);
    logic [15:0] e;
    regAddr <= a[4:0];
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 got = regRdData;
    e = model[a][15:0];
    if (a == OFS_CONTROL) e[1] = counterBusy;
    @(posedge ref_clk);
    chkReg(got, e);
  endtask

  task automatic pulse(input logic carry, input logic [15:0] cause);
    minuteCarry <= carry;
    causeEvent <= cause;
    @(posedge ref_clk);
    minuteCarry <= 1'b0;
    causeEvent <= 16'h0000;
    @(posedge ref_clk);
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    nErrors++;
    $display("watchdog expired");
    stop_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    regAddr = 5'h00;
    regWrData = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    minuteCarry = 1'b0;
    counterBusy = 1'b0;
    causeEvent = 16'h0000;
    for (int a = 0; a < 32; a += 2) model[a] = 0;
    for (int z = 0; z < NUM_ZONES; z++) begin
      model[OFS_HM_BASE + 2 * z] = 16'h1200;
      model[OFS_MD_BASE + 2 * z] = 16'h0101;
    end
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    // reset image, busy shown in control, one unmapped slot
    counterBusy <= 1'b1;
    for (int a = 0; a < 26; a += 2) rd(a);
    counterBusy <= 1'b0; // no calendar write while busy reads 1
    chkBit(hourFormat24, 1'b0);
    $display("test reset values done");
    // every zone copy holds its own value
    for (int z = 0; z < NUM_ZONES; z++) begin
      u = $random(seed);
      wr(2 * z, 16'h0300 + 16'h0111 * z + (z == 2 ? 16'h4000 : 16'h0000));
      wr(OFS_MD_BASE + 2 * z, 16'h1015 + z); // month never 0x00
      wr(OFS_YW_BASE + 2 * z, 16'((u % 7) << 8 | ((u >> 8) % 10) << 4
        | (u >> 16) % 10));
    end
    for (int a = 0; a < 18; a += 2) rd(a);
    $display("test zone copies done");
    // 12-hour stepping of zone main
    wr(0, 16'h1159);
    pulse(1'b1, 16'h0000);
    model[0] = 16'h5200;
    rd(0);
    wr(0, 16'h5259);
    pulse(1'b1, 16'h0000);
    model[0] = 16'h4100;
    rd(0);
    // afternoon flag survives the switch until the next hour step
    wr(0, 16'h5100);
    wr(OFS_CONTROL, 16'h0001);
    chkBit(hourFormat24, 1'b1);
    rd(0);
    wr(0, 16'h5159);
    rd(0);
    pulse(1'b1, 16'h0000);
    model[0] = 16'h1200;
    rd(0);
    wr(0, 16'h6359);
    rd(0);
    $display("test hour format done");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_MD_BASE, cal[i][0]);
      wr(OFS_YW_BASE, cal[i][1]);
      wr(0, 16'h2359);
      pulse(1'b1, 16'h0000);
      model[0] = 16'h0000;
      model[OFS_MD_BASE] = cal[i][2];
      model[OFS_YW_BASE] = cal[i][3];
      rd(0);
      rd(OFS_MD_BASE);
      rd(OFS_YW_BASE);
    end
    model[OFS_FLAGS] = 16'h00E0;
    rd(OFS_FLAGS);
    $display("test calendar done");
    // cause flags, enables and the request line
    wr(OFS_FLAGS, 16'hFFFF);
    u = $random(seed);
    c = 16'(u) | 16'h0100;
    pulse(1'b0, c);
    model[OFS_FLAGS] = c & EXT_CAUSE_MASK;
    rd(OFS_FLAGS);
    chkBit(irqRequest, 1'b0);
    wr(OFS_ENABLES, 16'hFFFF);
    rd(OFS_ENABLES);
    chkBit(irqRequest, 1'b1);
    wr(OFS_FLAGS, c & 16'h00FF);
    rd(OFS_FLAGS);
    wr(OFS_FLAGS, 16'h0000);
    rd(OFS_FLAGS);
    wr(OFS_FLAGS, 16'hFFFF);
    chkBit(irqRequest, 1'b0);
    pulse(1'b0, c);
    model[OFS_FLAGS] = c & EXT_CAUSE_MASK;
    chkBit(irqRequest, 1'b1);
    wr(OFS_ENABLES, 16'h0000);
    chkBit(irqRequest, 1'b0);
    rd(OFS_FLAGS);
    $display("test interrupt flags done");
    stop_test();
  end
endmodule

bind rtccal_regs rtccal_regs_checker #(.ZONES(ZONES)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .minuteCarry(minuteCarry),
  .counterBusy(counterBusy), .causeEvent(causeEvent),
  .irqRequest(irqRequest), .hourFormat24(hourFormat24));
